// file: core/qfthf_defines.vh
/*
 * Constants of the queue manager threshold and group hash filter block: register
 * indices, field positions, reset values and the interrupt bit layout.
 * Assumes an APB master with 32-bit data; byte address of a register is four times its index.
 */
// Overview of operation
// - With the receive threshold interrupt enable set, status bit 13 is set once buffered receive frames exceed the 8-bit threshold.
// - With the transmit memory monitor set, status bit 6 is set once transmit free space reaches the requested amount.
// - The 64-bit hash table filters group frames only when hash perfect mode is selected.
// - The hash index is the top six bits of the CRC over the 48-bit destination address.
// - The upper two index bits pick one of four hash words and the lower four pick the bit.
// - A group frame whose index hits a set table bit is accepted.
// - In hash mode, a group frame whose index hits a cleared table bit is dropped, unless accept-all and group-filter-with-own-address are both set.
// - With both accept-all and group-filter-with-own-address set, every group frame is accepted.
// - The transmit space status bit shows memory became available and clears on a written one.
`ifndef QFTHF_DEFINES_VH
`define QFTHF_DEFINES_VH

`define QFTHF_IDX_RX_THR 16'h019C
`define QFTHF_IDX_TX_REQ 16'h019E
`define QFTHF_IDX_HASH0 16'h01A0
`define QFTHF_IDX_HASH1 16'h01A2
`define QFTHF_IDX_HASH2 16'h01A4
`define QFTHF_IDX_HASH3 16'h01A6
`define QFTHF_IDX_RXQ_CTL 16'h01C0
`define QFTHF_IDX_TXQ_CTL 16'h01C2
`define QFTHF_IDX_RXC_ONE 16'h01C4
`define QFTHF_IDX_FILT_CTL 16'h01C6
`define QFTHF_IDX_INT_STAT 16'h01C8
`define QFTHF_IDX_INT_CLR 16'h01CA
`define QFTHF_IDX_INT_EN 16'h01CC

`define QFTHF_RST_REG 16'h0000
`define QFTHF_RXQ_THR_IE 5
`define QFTHF_TXQ_MEM_MON 1
`define QFTHF_RXC_ALL 4
`define QFTHF_RXC_MC_OWN 8
`define QFTHF_FILT_HASH 0
`define QFTHF_INT_RX_THR 13
`define QFTHF_INT_TX_SPACE 6
`define QFTHF_INT_MASK 16'h2040
`define QFTHF_CRC_POLY 32'h04C11DB7
`define QFTHF_CRC_INIT 32'hFFFFFFFF

`endif

// file: core/qfthf_core.v
/*
 * Queue manager receive threshold, transmit space request and 64-bit group hash
 * filter, with an APB register slave and one level interrupt.
 * Assumes queue counters and the frame filter request come from logic on clk_sys.
 */
`timescale 1ns/1ns
`include "qfthf_defines.vh"

module qfthf_core #(
    parameter ADDR_W = 16,
    parameter DATA_W = 32
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [ADDR_W-1:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [DATA_W-1:0] pwdata,
    output reg [DATA_W-1:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [7:0] rxFrameCount,
    input wire [15:0] txFreeSpace,
    input wire daValid,
    input wire [47:0] destAddr,
    output reg filtValid,
    output reg filtAccept,
    output reg filtMulticast,
    output reg irq
);

    // One-hot register select shared by the read mux and the write strobes
    localparam SEL_HASH0 = 0;
    localparam SEL_HASH1 = 1;
    localparam SEL_HASH2 = 2;
    localparam SEL_HASH3 = 3;
    localparam SEL_RX_THR = 4;
    localparam SEL_TX_REQ = 5;
    localparam SEL_RXQ_CTL = 6;
    localparam SEL_TXQ_CTL = 7;
    localparam SEL_RXC_ONE = 8;
    localparam SEL_FILT_CTL = 9;
    localparam SEL_INT_STAT = 10;
    localparam SEL_INT_CLR = 11;
    localparam SEL_INT_EN = 12;
    localparam N_SEL = 13;

    // Registers sit on aligned words: the byte address is four times the index
    function regHit;
        input [ADDR_W-1:0] addr;
        input [15:0] idx;
        begin
            regHit = (addr == {idx[ADDR_W-3:0], 2'b00});
        end
    endfunction

    function [N_SEL-1:0] regDecode;
        input [ADDR_W-1:0] addr;
        begin
            regDecode = {N_SEL{1'b0}};
            regDecode[SEL_HASH0] = regHit(addr, `QFTHF_IDX_HASH0);
            regDecode[SEL_HASH1] = regHit(addr, `QFTHF_IDX_HASH1);
            regDecode[SEL_HASH2] = regHit(addr, `QFTHF_IDX_HASH2);
            regDecode[SEL_HASH3] = regHit(addr, `QFTHF_IDX_HASH3);
            regDecode[SEL_RX_THR] = regHit(addr, `QFTHF_IDX_RX_THR);
            regDecode[SEL_TX_REQ] = regHit(addr, `QFTHF_IDX_TX_REQ);
            regDecode[SEL_RXQ_CTL] = regHit(addr, `QFTHF_IDX_RXQ_CTL);
            regDecode[SEL_TXQ_CTL] = regHit(addr, `QFTHF_IDX_TXQ_CTL);
            regDecode[SEL_RXC_ONE] = regHit(addr, `QFTHF_IDX_RXC_ONE);
            regDecode[SEL_FILT_CTL] = regHit(addr, `QFTHF_IDX_FILT_CTL);
            regDecode[SEL_INT_STAT] = regHit(addr, `QFTHF_IDX_INT_STAT);
            regDecode[SEL_INT_CLR] = regHit(addr, `QFTHF_IDX_INT_CLR);
            regDecode[SEL_INT_EN] = regHit(addr, `QFTHF_IDX_INT_EN);
        end
    endfunction

    // Serial CRC-32 over the address, least significant bit of each byte first
    function [31:0] daCrc;
        input [47:0] da;
        integer i;
        reg [31:0] c;
        reg fb;
        begin
            c = `QFTHF_CRC_INIT;
            for (i = 0; i < 48; i = i + 1) begin
                fb = c[31] ^ da[40 - 8 * (i / 8) + (i % 8)];
                c = {c[30:0], 1'b0} ^ (fb ? `QFTHF_CRC_POLY : 32'h00000000);
            end
            daCrc = c;
        end
    endfunction

    reg [15:0] rxThreshold_q;
    reg [15:0] txSpaceReq_q;
    reg [15:0] hashWord_q [0:3];
    reg [15:0] rxQueueCtl_q;
    reg [15:0] txQueueCtl_q;
    reg [15:0] rxCtlOne_q;
    reg [15:0] filterCtl_q;
    reg [15:0] intStatus_q;
    reg [15:0] intStatus_d;
    reg [15:0] intEnable_q;
    reg rxAbove_q;
    reg txRoom_q;

    wire [N_SEL-1:0] sel = regDecode(paddr);
    wire setupPhase = psel & ~penable;
    wire wrEn = psel & penable & pready & pwrite;
    wire [N_SEL-1:0] wrSel = wrEn ? sel : {N_SEL{1'b0}};
    wire [15:0] wData = pwdata[15:0];
    // An address outside the map answers with an error and reads zero
    wire mapped = |sel;

    reg [15:0] rdData;

    // Selects are one-hot so no branch overrides another; the clear register reads zero
    always @* begin
        rdData = 16'h0000;
        if (sel[SEL_HASH0]) begin
            rdData = hashWord_q[0];
        end
        if (sel[SEL_HASH1]) begin
            rdData = hashWord_q[1];
        end
        if (sel[SEL_HASH2]) begin
            rdData = hashWord_q[2];
        end
        if (sel[SEL_HASH3]) begin
            rdData = hashWord_q[3];
        end
        if (sel[SEL_RX_THR]) begin
            rdData = rxThreshold_q;
        end
        if (sel[SEL_TX_REQ]) begin
            rdData = txSpaceReq_q;
        end
        if (sel[SEL_RXQ_CTL]) begin
            rdData = rxQueueCtl_q;
        end
        if (sel[SEL_TXQ_CTL]) begin
            rdData = txQueueCtl_q;
        end
        if (sel[SEL_RXC_ONE]) begin
            rdData = rxCtlOne_q;
        end
        if (sel[SEL_FILT_CTL]) begin
            rdData = filterCtl_q;
        end
        if (sel[SEL_INT_STAT]) begin
            rdData = intStatus_q;
        end
        if (sel[SEL_INT_EN]) begin
            rdData = intEnable_q;
        end
    end

    // Bus slave: data and error are captured in the setup cycle, answer in the access cycle
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setupPhase;
            if (setupPhase) begin
                prdata <= {16'h0000, rdData};
                pslverr <= ~mapped;
            end else if (pready) begin
                pslverr <= 1'b0;
            end
        end
    end

    // Threshold of one while receiving misbehaves; the block does not guard against it
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxThreshold_q <= `QFTHF_RST_REG;
        end else if (wrSel[SEL_RX_THR]) begin
            rxThreshold_q <= wData;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            txSpaceReq_q <= `QFTHF_RST_REG;
        end else if (wrSel[SEL_TX_REQ]) begin
            txSpaceReq_q <= wData;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxQueueCtl_q <= `QFTHF_RST_REG;
        end else if (wrSel[SEL_RXQ_CTL]) begin
            rxQueueCtl_q <= wData;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            txQueueCtl_q <= `QFTHF_RST_REG;
        end else if (wrSel[SEL_TXQ_CTL]) begin
            txQueueCtl_q <= wData;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxCtlOne_q <= `QFTHF_RST_REG;
        end else if (wrSel[SEL_RXC_ONE]) begin
            rxCtlOne_q <= wData;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            filterCtl_q <= `QFTHF_RST_REG;
        end else if (wrSel[SEL_FILT_CTL]) begin
            filterCtl_q <= wData;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            intEnable_q <= `QFTHF_RST_REG;
        end else if (wrSel[SEL_INT_EN]) begin
            intEnable_q <= wData;
        end
    end

    // Hash word g is picked by select line SEL_HASH0 + g, the same order the filter indexes
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : genHash
            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    hashWord_q[g] <= `QFTHF_RST_REG;
                end else if (wrSel[SEL_HASH0 + g]) begin
                    hashWord_q[g] <= wData;
                end
            end
        end
    endgenerate

    wire rxAbove = rxFrameCount > rxThreshold_q[7:0];
    wire txRoom = txFreeSpace >= txSpaceReq_q;
    // Events are edge triggered so a lasting condition does not re-raise after a clear
    wire setRx = rxQueueCtl_q[`QFTHF_RXQ_THR_IE] & rxAbove & ~rxAbove_q;
    wire setTx = txQueueCtl_q[`QFTHF_TXQ_MEM_MON] & txRoom & ~txRoom_q;
    wire [15:0] clrBits = wrSel[SEL_INT_CLR] ? wData : 16'h0000;

    always @* begin
        // Set wins over a clear in the same cycle
        intStatus_d = (intStatus_q & ~clrBits) & `QFTHF_INT_MASK;
        intStatus_d[`QFTHF_INT_RX_THR] = intStatus_d[`QFTHF_INT_RX_THR] | setRx;
        intStatus_d[`QFTHF_INT_TX_SPACE] = intStatus_d[`QFTHF_INT_TX_SPACE] | setTx;
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            intStatus_q <= `QFTHF_RST_REG;
            rxAbove_q <= 1'b0;
            txRoom_q <= 1'b0;
            irq <= 1'b0;
        end else begin
            intStatus_q <= intStatus_d;
            rxAbove_q <= rxAbove;
            txRoom_q <= txRoom;
            // One cycle behind status, so the level output comes straight from a flip-flop
            irq <= |(intStatus_q & intEnable_q);
        end
    end

    wire [31:0] crcVal = daCrc(destAddr);
    wire [5:0] hashIdx = crcVal[31:26];
    wire [15:0] hashSel = hashWord_q[hashIdx[5:4]];
    wire hashBit = hashSel[hashIdx[3:0]];
    // Unicast frames, and group frames outside hash mode, always pass
    wire isGroup = destAddr[40];
    wire passAll = rxCtlOne_q[`QFTHF_RXC_ALL] & rxCtlOne_q[`QFTHF_RXC_MC_OWN];
    wire hashOn = filterCtl_q[`QFTHF_FILT_HASH];

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            filtValid <= 1'b0;
            filtAccept <= 1'b0;
            filtMulticast <= 1'b0;
        end else begin
            filtValid <= daValid;
            filtMulticast <= daValid & isGroup;
            if (!daValid) begin
                filtAccept <= 1'b0;
            end else if (!isGroup || passAll) begin
                filtAccept <= 1'b1;
            end else if (hashOn) begin
                filtAccept <= hashBit;
            end else begin
                filtAccept <= 1'b1;
            end
        end
    end

endmodule

// file: testbench/qfthf_core_properties.sv
/* Checker of APB answer and frame filter timing of qfthf_core.
   Assumes it is bound to qfthf_core and sees only its ports. */
`timescale 1ns/1ns
module qfthf_core_props (
    input wire clk_sys,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire daValid,
    input wire [47:0] destAddr,
    input wire filtValid,
    input wire filtAccept,
    input wire filtMulticast,
    input wire irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_setup_answer: assert property (psel && !penable |=> pready) else $error("no answer");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
    a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0) else $error("upper bits set");
    a_filt_latency: assert property (filtValid == $past(daValid)) else $error("filter latency");
    a_group_flag: assert property (daValid |=> filtMulticast == $past(destAddr[40])) else $error("group flag");
    a_unicast_pass: assert property (daValid && !destAddr[40] |=> filtAccept) else $error("unicast drop");
    a_idle_low: assert property (!filtValid |-> !filtAccept && !filtMulticast) else $error("idle not low");
    c_accept: cover property (filtValid && filtMulticast && filtAccept);
    c_drop: cover property (filtValid && filtMulticast && !filtAccept);
    c_irq: cover property ($rose(irq));
endmodule
bind qfthf_core qfthf_core_props qfthf_core_props_i (.clk_sys, .rst_n, .psel, .penable, .prdata, .pready,
    .pslverr, .daValid, .destAddr, .filtValid, .filtAccept, .filtMulticast, .irq);

// file: testbench/qfthf_host.sv
/* APB host processor model, one transfer per call of xfer.
   Assumes the slave answers with pready; only the bench timeout ends a hang. */
`timescale 1ns/1ns
module qfthf_host (
    input wire clk_sys,
    output reg psel = 1'b0,
    output reg penable = 1'b0,
    output reg pwrite = 1'b0,
    output reg [15:0] paddr = 16'h0000,
    output reg [31:0] pwdata = 32'h00000000,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    task xfer(input [15:0] a, input w, input [31:0] d, output [31:0] r, output e);
        @(posedge clk_sys);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data shows a changed pattern, not the last value
        pwdata <= ~d;
    endtask
endmodule

// file: testbench/qfthf_core_test.sv
/* Self-checking bench of qfthf_core: register map, group hash filter, interrupts.
   Assumes the host model and the bound checker are compiled with it. */
`timescale 1ns/1ns
`include "qfthf_defines.vh"
module qfthf_core_test;
    typedef struct {logic [15:0] a; logic [31:0] w; logic [31:0] e; logic er;} qfthf_row_t;
    qfthf_row_t rows [0:13] = '{
        '{`QFTHF_IDX_RX_THR, 32'hFFFFABCD, 32'h0000ABCD, 1'b0},
        '{`QFTHF_IDX_TX_REQ, 32'hFFFF1234, 32'h00001234, 1'b0},
        '{`QFTHF_IDX_HASH0, 32'h00005A5A, 32'h00005A5A, 1'b0},
        '{16'h01A2, 32'h0000A5A5, 32'h0000A5A5, 1'b0},
        '{16'h01A4, 32'h00000F0F, 32'h00000F0F, 1'b0},
        '{16'h01A6, 32'h0000F0F0, 32'h0000F0F0, 1'b0},
        '{`QFTHF_IDX_RXQ_CTL, 32'h0000FFFF, 32'h0000FFFF, 1'b0},
        '{`QFTHF_IDX_TXQ_CTL, 32'h0000FFFF, 32'h0000FFFF, 1'b0},
        '{`QFTHF_IDX_RXC_ONE, 32'h0000FEEF, 32'h0000FEEF, 1'b0},
        '{`QFTHF_IDX_FILT_CTL, 32'h0000FFFE, 32'h0000FFFE, 1'b0},
        '{`QFTHF_IDX_INT_STAT, 32'h0000FFFF, 32'h00000000, 1'b0},
        '{`QFTHF_IDX_INT_CLR, 32'h0000FFFF, 32'h00000000, 1'b0},
        '{`QFTHF_IDX_INT_EN, 32'h0000FFFF, 32'h0000FFFF, 1'b0},
        '{16'h01FF, 32'h00001234, 32'h00000000, 1'b1}};
    reg clk_sys = 1'b0;
    reg rst_n = 1'b0;
    reg [7:0] rxFrameCount = 8'h00;
    reg [15:0] txFreeSpace = 16'h0000;
    reg daValid = 1'b0;
    reg [47:0] destAddr = 48'h000000000000;
    wire psel, penable, pwrite, pready, pslverr, filtValid, filtAccept, filtMulticast, irq;
    wire [15:0] paddr;
    wire [31:0] pwdata, prdata;
    integer n_mismatch = 0, samples_checked = 0, cyc = 0, i;
    reg [31:0] r;
    reg e;
    reg [5:0] hidx;
    always #2 clk_sys = ~clk_sys;
    qfthf_host qfthf_host_i (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    qfthf_core qfthf_core_i (.clk_sys, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .rxFrameCount, .txFreeSpace, .daValid, .destAddr, .filtValid, .filtAccept, .filtMulticast, .irq);
    task results;
        if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input [15:0] a, input [31:0] d);
        qfthf_host_i.xfer(a << 2, 1'b1, d, r, e);
    endtask
    task rd(input [15:0] a, input [31:0] x, input xe);
        qfthf_host_i.xfer(a << 2, 1'b0, 32'h0, r, e);
        chk(r, x);
        chk(e, xe);
    endtask
    // Byte [47:40] goes first, each byte least significant bit first
    function [5:0] hash6(input [47:0] da);
        reg [31:0] c;
        integer k;
        c = 32'hFFFFFFFF;
        for (k = 0; k < 48; k = k + 1)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ da[40 - 8 * (k / 8) + k % 8]) ? `QFTHF_CRC_POLY : 32'h0);
        hash6 = c[31:26];
    endfunction
    task filt(input [47:0] da, input x);
        @(posedge clk_sys);
        daValid <= 1'b1;
        destAddr <= da;
        @(posedge clk_sys);
        daValid <= 1'b0;
        destAddr <= ~da;
        @(posedge clk_sys);
        chk(filtValid, 1);
        chk(filtAccept, x);
        chk(filtMulticast, da[40]);
    endtask
    // Ceiling well above the few hundred cycles of the sequence
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            results;
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (i = 0; i < 14; i = i + 1) begin
            rd(rows[i].a, 32'h0, rows[i].er);
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].e, rows[i].er);
        end
        hidx = hash6(48'h01005E0000FB);
        for (i = 0; i < 4; i = i + 1) wr(`QFTHF_IDX_HASH0 + 2 * i, 32'h0);
        filt(48'h01005E0000FB, 1'b1);
        wr(`QFTHF_IDX_FILT_CTL, 32'h1);
        filt(48'h01005E0000FB, 1'b0);
        wr(`QFTHF_IDX_HASH0 + 2 * hidx[5:4], 32'h1 << hidx[3:0]);
        filt(48'h01005E0000FB, 1'b1);
        wr(`QFTHF_IDX_HASH0 + 2 * hidx[5:4], 32'h0);
        wr(`QFTHF_IDX_RXC_ONE, 32'h0110);
        filt(48'h01005E0000FB, 1'b1);
        wr(`QFTHF_IDX_RXC_ONE, 32'h0010);
        filt(48'h01005E0000FB, 1'b0);
        wr(`QFTHF_IDX_INT_EN, 32'h0);
        wr(`QFTHF_IDX_RX_THR, 32'h3);
        wr(`QFTHF_IDX_RXQ_CTL, 32'h20);
        rxFrameCount <= 8'h03;
        rd(`QFTHF_IDX_INT_STAT, 32'h0, 1'b0);
        rxFrameCount <= 8'h04;
        rd(`QFTHF_IDX_INT_STAT, 32'h2000, 1'b0);
        chk(irq, 0);
        wr(`QFTHF_IDX_INT_EN, 32'h2040);
        repeat (2) @(posedge clk_sys);
        chk(irq, 1);
        wr(`QFTHF_IDX_INT_CLR, 32'h2000);
        rd(`QFTHF_IDX_INT_STAT, 32'h0, 1'b0);
        chk(irq, 0);
        wr(`QFTHF_IDX_TX_REQ, 32'h10);
        wr(`QFTHF_IDX_TXQ_CTL, 32'h2);
        txFreeSpace <= 16'h000F;
        rd(`QFTHF_IDX_INT_STAT, 32'h0, 1'b0);
        txFreeSpace <= 16'h0010;
        rd(`QFTHF_IDX_INT_STAT, 32'h0040, 1'b0);
        chk(irq, 1);
        wr(`QFTHF_IDX_INT_CLR, 32'h0040);
        rd(`QFTHF_IDX_INT_STAT, 32'h0, 1'b0);
        // Reset in mid-run must bring the programmed registers back to zero
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(irq, 0);
        rst_n <= 1'b1;
        rd(`QFTHF_IDX_TX_REQ, 32'h0, 1'b0);
        rd(`QFTHF_IDX_INT_EN, 32'h0, 1'b0);
        results;
    end
endmodule
